// ===== logic/wkpc_pkg.sv
/*
 wake-up and low-power pad control bank: offsets, reset values, field layouts and bus types.
 assumes a single AHB-Lite master with 32-bit words and word-aligned registers.
*/
package wkpc_pkg;
   localparam int          WKPC_PADS       = 5;
   localparam logic [7:0]  WKPC_OFF_LEVEL  = 8'h00;
   localparam logic [7:0]  WKPC_OFF_ENABLE = 8'h04;
   localparam logic [7:0]  WKPC_OFF_CTRL   = 8'h08;
   localparam logic [7:0]  WKPC_OFF_OEN    = 8'h0c;
   localparam logic [7:0]  WKPC_OFF_OUT    = 8'h10;
   localparam logic [7:0]  WKPC_OFF_DS     = 8'h14;
   localparam logic [7:0]  WKPC_OFF_PE     = 8'h18;
   localparam logic [4:0]  WKPC_RST_LEVEL  = 5'h00;
   localparam logic [4:0]  WKPC_RST_ENABLE = 5'h07;
   localparam logic        WKPC_RST_CTRL   = 1'h0;
   localparam logic [4:0]  WKPC_RST_OEN    = 5'h07;
   localparam logic [4:0]  WKPC_RST_OUT    = 5'h00;
   localparam logic [4:0]  WKPC_RST_DS     = 5'h00;
   localparam logic [4:0]  WKPC_RST_PE     = 5'h00;
   localparam int          WKPC_FAST_XTAL_BIT = 0;
   localparam logic [1:0]  WKPC_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  WKPC_HTRANS_SEQ    = 2'h3;

   typedef logic [WKPC_PADS-1:0] wkpc_pads_t;

   // low-power pad settings travelling together to the pad ring
   typedef struct packed {
      wkpc_pads_t oe;
      wkpc_pads_t out;
      wkpc_pads_t ds;
      wkpc_pads_t pe;
   } wkpc_pad_cfg_s;

   // captured address phase
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
   } wkpc_aphase_s;
endpackage

// ===== logic/wkpc_top.sv
/*
 wake-up and low-power pad control register bank with an AHB-Lite slave port.
 assumes the wake pads and low-power state come from outside this clock domain,
 and that the pad ring picks the low-power settings only while LP_MODE_O is high.
*/
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module wkpc_top
   import wkpc_pkg::*;
(
   // clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   // ahb-lite slave
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // wake pads and power state
   input  wire logic [4:0]  WAKE_PAD_I,
   input  wire logic        LOW_POWER_I,
   output logic             WAKE_REQ_O,
   output logic             FAST_CRYSTAL_O,
   // low-power pad control
   output logic             LP_MODE_O,
   output logic      [4:0]  LP_PAD_OE_O,
   output logic      [4:0]  LP_PAD_OUT_O,
   output logic      [4:0]  LP_PAD_DS_O,
   output logic      [4:0]  LP_PAD_PE_O
);

   // data-phase tracker, gray coded along idle, write, read
   typedef enum logic [1:0] {
      WKPC_PH_IDLE  = 2'b00,
      WKPC_PH_WRITE = 2'b01,
      WKPC_PH_READ  = 2'b11
   } wkpc_phase_e;

   // bus side
   wkpc_phase_e   phase_reg;
   wkpc_phase_e   phase_next;
   wkpc_aphase_s  aph_reg;
   wkpc_aphase_s  aph_next;
   logic          wr_strobe;
   logic          rd_take;
   logic [31:0]   rdata_next;
   // software-visible fields
   wkpc_pads_t    level_reg;
   wkpc_pads_t    enable_reg;
   logic          fast_crystal_flag_reg;
   wkpc_pads_t    oe_reg;
   wkpc_pads_t    out_reg;
   wkpc_pads_t    ds_reg;
   wkpc_pads_t    pe_reg;
   wkpc_pad_cfg_s cfg_now;
   // synchronisers and wake
   wkpc_pads_t    pad_meta_reg;
   wkpc_pads_t    pad_sync_reg;
   logic          lp_meta_reg;
   logic          lp_sync_reg;
   wkpc_pads_t    pad_match;
   logic          wake_next;

   // zero-extend a five-bit field into a bus word
   function automatic logic [31:0] wkpc_word(input wkpc_pads_t f);
      return {27'h0000000, f};
   endfunction

   // a selected NONSEQ or SEQ beat starts a transfer
   function automatic logic wkpc_is_xfer(input logic sel, input logic [1:0] trans);
      return sel && (trans == WKPC_HTRANS_NONSEQ || trans == WKPC_HTRANS_SEQ);
   endfunction

   // word decode of a captured address against a register offset
   function automatic logic wkpc_hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction

   // ds and pe leave the block only in low power, else the inactive level
   function automatic wkpc_pads_t wkpc_lp_gate(input logic lp, input wkpc_pads_t f, input wkpc_pads_t idle);
      return lp ? f : idle;
   endfunction

   // bus slave
   // address phase capture; the slave never stretches a transfer
   always_comb begin
      aph_next.wr   = HWRITE_I;
      aph_next.addr = {HADDR_I[7:2], 2'h0};
   end

   // a data phase follows every taken address phase
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         WKPC_PH_IDLE, WKPC_PH_WRITE, WKPC_PH_READ: begin
            if (HREADY_I) begin
               if (!wkpc_is_xfer(HSEL_I, HTRANS_I)) begin
                  phase_next = WKPC_PH_IDLE;
               end else if (aph_next.wr) begin
                  phase_next = WKPC_PH_WRITE;
               end else begin
                  phase_next = WKPC_PH_READ;
               end
            end
         end
         default: begin
            phase_next = WKPC_PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         phase_reg <= WKPC_PH_IDLE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // address held for the data phase
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         aph_reg <= '0;
      end else if (HREADY_I) begin
         aph_reg <= aph_next;
      end
   end

   // zero wait states
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         HREADYOUT_O <= 1'b1;
      end else begin
         HREADYOUT_O <= 1'b1;
      end
   end

   // every response is OKAY
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         HRESP_O <= 1'b0;
      end else begin
         HRESP_O <= 1'b0;
      end
   end

   // writes land in the data phase, reads are muxed in the address phase
   assign wr_strobe = (phase_reg == WKPC_PH_WRITE) && aph_reg.wr;
   assign rd_take   = HREADY_I && wkpc_is_xfer(HSEL_I, HTRANS_I) && !aph_next.wr;

   // software registers; reserved bits are never stored
   // wake level per pad
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         level_reg <= WKPC_RST_LEVEL;
      end else if (wr_strobe && wkpc_hit(aph_reg.addr, WKPC_OFF_LEVEL)) begin
         level_reg <= HWDATA_I[WKPC_PADS-1:0];
      end
   end

   // wake source enable per pad
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         enable_reg <= WKPC_RST_ENABLE;
      end else if (wr_strobe && wkpc_hit(aph_reg.addr, WKPC_OFF_ENABLE)) begin
         enable_reg <= HWDATA_I[WKPC_PADS-1:0];
      end
   end

   // crystal indication, one for the fast crystal
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fast_crystal_flag_reg <= WKPC_RST_CTRL;
      end else if (wr_strobe && wkpc_hit(aph_reg.addr, WKPC_OFF_CTRL)) begin
         fast_crystal_flag_reg <= HWDATA_I[WKPC_FAST_XTAL_BIT];
      end
   end

   // low-power output enable
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         oe_reg <= WKPC_RST_OEN;
      end else if (wr_strobe && wkpc_hit(aph_reg.addr, WKPC_OFF_OEN)) begin
         oe_reg <= HWDATA_I[WKPC_PADS-1:0];
      end
   end

   // low-power output value, read back as written
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         out_reg <= WKPC_RST_OUT;
      end else if (wr_strobe && wkpc_hit(aph_reg.addr, WKPC_OFF_OUT)) begin
         out_reg <= HWDATA_I[WKPC_PADS-1:0];
      end
   end

   // low-power drive strength
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ds_reg <= WKPC_RST_DS;
      end else if (wr_strobe && wkpc_hit(aph_reg.addr, WKPC_OFF_DS)) begin
         ds_reg <= HWDATA_I[WKPC_PADS-1:0];
      end
   end

   // low-power pull enable
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pe_reg <= WKPC_RST_PE;
      end else if (wr_strobe && wkpc_hit(aph_reg.addr, WKPC_OFF_PE)) begin
         pe_reg <= HWDATA_I[WKPC_PADS-1:0];
      end
   end

   // pad settings travel together to the output stage
   always_comb begin
      cfg_now.oe  = oe_reg;
      cfg_now.out = out_reg;
      cfg_now.ds  = ds_reg;
      cfg_now.pe  = pe_reg;
   end

   // read mux from address phase so data stands in the data phase
   always_comb begin
      case (aph_next.addr)
         WKPC_OFF_LEVEL:  rdata_next = wkpc_word(level_reg);
         WKPC_OFF_ENABLE: rdata_next = wkpc_word(enable_reg);
         WKPC_OFF_CTRL:   rdata_next = {31'h00000000, fast_crystal_flag_reg};
         WKPC_OFF_OEN:    rdata_next = wkpc_word(oe_reg);
         WKPC_OFF_OUT:    rdata_next = wkpc_word(out_reg);
         WKPC_OFF_DS:     rdata_next = wkpc_word(ds_reg);
         WKPC_OFF_PE:     rdata_next = wkpc_word(pe_reg);
         default:         rdata_next = 32'h00000000;
      endcase
   end

   // held until the next read address phase; a read right after a write sees the old value
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         HRDATA_O <= 32'h00000000;
      end else if (rd_take) begin
         HRDATA_O <= rdata_next;
      end
   end

   // wake pad synchroniser
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pad_meta_reg <= '0;
         pad_sync_reg <= '0;
      end else begin
         pad_meta_reg <= WAKE_PAD_I;
         pad_sync_reg <= pad_meta_reg;
      end
   end

   // power-state synchroniser
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         lp_meta_reg <= 1'b0;
         lp_sync_reg <= 1'b0;
      end else begin
         lp_meta_reg <= LOW_POWER_I;
         lp_sync_reg <= lp_meta_reg;
      end
   end

   // per-pad match: bit n is wake_pad_n, level 0 wakes on low and 1 on high
   always_comb begin
      for (int n = 0; n < WKPC_PADS; n++) begin
         pad_match[n] = enable_reg[n] && (pad_sync_reg[n] == level_reg[n]);
      end
   end

   assign wake_next = lp_sync_reg && (|pad_match);

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         WAKE_REQ_O <= 1'b0;
      end else begin
         WAKE_REQ_O <= wake_next;
      end
   end

   // low-power pad outputs
   // pad ring picks the low-power settings while this is high
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         LP_MODE_O <= 1'b0;
      end else begin
         LP_MODE_O <= lp_sync_reg;
      end
   end

   // output enable
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         LP_PAD_OE_O <= WKPC_RST_OEN;
      end else begin
         LP_PAD_OE_O <= cfg_now.oe;
      end
   end

   // output value only where the pad is an output
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         LP_PAD_OUT_O <= WKPC_RST_OUT;
      end else begin
         LP_PAD_OUT_O <= cfg_now.out & cfg_now.oe;
      end
   end

   // drive strength
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         LP_PAD_DS_O <= WKPC_RST_DS;
      end else begin
         LP_PAD_DS_O <= wkpc_lp_gate(lp_sync_reg, cfg_now.ds, WKPC_RST_DS);
      end
   end

   // pull enable
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         LP_PAD_PE_O <= WKPC_RST_PE;
      end else begin
         LP_PAD_PE_O <= wkpc_lp_gate(lp_sync_reg, cfg_now.pe, WKPC_RST_PE);
      end
   end

   // crystal indication to the clock logic
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FAST_CRYSTAL_O <= WKPC_RST_CTRL;
      end else begin
         FAST_CRYSTAL_O <= fast_crystal_flag_reg;
      end
   end

endmodule // wkpc_top

// ===== test/wkpc_asserts.sv
/*
 checker for wkpc_top: bus answer, reserved bits, pad gating, wake and crystal flag timing.
 assumes LOW_POWER_I is held low while RST_N_I is low.
*/
`timescale 1ns/1ps
module wkpc_asserts (
   input wire logic        SYS_CLK_I, RST_N_I, HSEL_I, HWRITE_I, HREADY_I, HREADYOUT_O, HRESP_O,
   input wire logic        LOW_POWER_I, WAKE_REQ_O, FAST_CRYSTAL_O, LP_MODE_O,
   input wire logic [1:0]  HTRANS_I,
   input wire logic [31:0] HADDR_I, HWDATA_I, HRDATA_O,
   input wire logic [4:0]  LP_PAD_OE_O, LP_PAD_OUT_O, LP_PAD_DS_O, LP_PAD_PE_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_ctrl_wr;
      HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I && HADDR_I[7:2] == 6'h02;
   endsequence
   property p_xtal;
      s_ctrl_wr |-> ##3 (FAST_CRYSTAL_O == $past(HWDATA_I[0], 2));
   endproperty
   a_ready_okay: assert property (HREADYOUT_O && !HRESP_O) else $error("bus answer not ready or okay");
   a_rdata_reserved: assert property (HRDATA_O[31:5] == 27'h0) else $error("reserved read bits set");
   a_lp_sync: assert property (LP_MODE_O == $past(LOW_POWER_I, 3)) else $error("low-power state late");
   a_ds_gated: assert property (!LP_MODE_O |-> LP_PAD_DS_O == 5'h0) else $error("drive strength leaks");
   a_pe_gated: assert property (!LP_MODE_O |-> LP_PAD_PE_O == 5'h0) else $error("pull enable leaks");
   a_wake_gated: assert property (WAKE_REQ_O |-> LP_MODE_O) else $error("wake outside low power");
   a_xtal_write: assert property (p_xtal) else $error("crystal flag not written");
   a_oe_reset: assert property ($rose(RST_N_I) |-> LP_PAD_OE_O == 5'h07) else $error("output enable reset");
   a_out_masked: assert property ((LP_PAD_OUT_O & ~LP_PAD_OE_O) == 5'h0) else $error("output value unmasked");
endmodule // wkpc_asserts
bind wkpc_top wkpc_asserts u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HWRITE_I(HWRITE_I),
   .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .LOW_POWER_I(LOW_POWER_I),
   .WAKE_REQ_O(WAKE_REQ_O), .FAST_CRYSTAL_O(FAST_CRYSTAL_O), .LP_MODE_O(LP_MODE_O), .HTRANS_I(HTRANS_I),
   .HADDR_I(HADDR_I), .HWDATA_I(HWDATA_I), .HRDATA_O(HRDATA_O), .LP_PAD_OE_O(LP_PAD_OE_O),
   .LP_PAD_OUT_O(LP_PAD_OUT_O), .LP_PAD_DS_O(LP_PAD_DS_O), .LP_PAD_PE_O(LP_PAD_PE_O));

// ===== test/tb_top.sv
/*
 bench for wkpc_top: reset values, read-back, reserved bits, pad gating and wake request.
 assumes a zero wait-state slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module tb_top;
   import wkpc_pkg::*;
   logic        clk = 0, rst_n = 0, hwrite = 0, lp = 0, obs = 0, sel = 1, lpv, rdy, resp, wake, fast, lpm;
   logic [31:0] haddr = 0, hwdata = 0, rdata, e, got;
   logic [1:0]  htrans = 0;
   logic [4:0]  pads = 0, pv, oe, out, ds, pe;
   logic [32:0] q[$], nt;
   logic [31:0] rv [7];
   logic [31:0] rst [8] = '{0, 7, 0, 7, 0, 0, 0, 0};
   int          err_count = 0, checks = 0;
   always #50 clk = ~clk;
   wkpc_top dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(sel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy), .HRDATA_O(rdata),
      .HREADYOUT_O(rdy), .HRESP_O(resp), .WAKE_PAD_I(pads), .LOW_POWER_I(lp), .WAKE_REQ_O(wake),
      .FAST_CRYSTAL_O(fast), .LP_MODE_O(lpm), .LP_PAD_OE_O(oe), .LP_PAD_OUT_O(out), .LP_PAD_DS_O(ds),
      .LP_PAD_PE_O(pe));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wait_rdy;
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) begin
         $display("CHECK FAILED %0t bus ready timeout", $time);
         err_count++;
         stop_test();
      end
   endtask
   // one single transfer, then an idle cycle; reads leave a note
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= WKPC_HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      if (!wr) q.push_back({1'b0, x});
      obs <= !wr;
      wait_rdy();
      obs <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pad_chk(input logic [31:0] x);
      repeat (4) @(posedge clk);
      q.push_back({1'b1, x});
      obs <= 1'b1;
      @(posedge clk);
      obs <= 1'b0;
   endtask
   always @(posedge clk) begin
      if (obs && rdy === 1'b1) begin
         nt = q.pop_front();
         got = nt[32] ? {9'h0, wake, fast, lpm, oe, out, ds, pe} : rdata;
         checks++;
         if (got !== nt[31:0]) begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, nt[31:0]);
         end
      end
   end
   initial begin
      void'($urandom(2865));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) xfer(0, 8'(4 * i), 0, rst[i]);
      for (int k = 0; k < 8; k++) begin
         foreach (rv[i]) begin
            rv[i] = $urandom();
            xfer(1, 8'(4 * i), rv[i], 0);
            xfer(0, 8'(4 * i), 0, rv[i] & (i == 2 ? 32'h1 : 32'h1f));
         end
         sel <= 1'b0;
         xfer(1, 8'h00, ~rv[0], 0);
         sel <= 1'b1;
         xfer(0, 8'h00, 0, rv[0] & 32'h1f);
         xfer(1, 8'h1c, $urandom(), 0);
         xfer(0, 8'h1c, 0, 0);
         pv = 5'($urandom());
         lpv = k[0];
         pads <= pv;
         lp <= lpv;
         e = {9'h0, lpv & |(rv[1][4:0] & ~(pv ^ rv[0][4:0])), rv[2][0], lpv, rv[3][4:0],
              rv[4][4:0] & rv[3][4:0], rv[5][4:0] & {5{lpv}}, rv[6][4:0] & {5{lpv}}};
         pad_chk(e);
      end
      stop_test();
   end
endmodule // tb_top
